// ### hw/scsiwv_pkg.sv
// constants, register map and types for the write/verify command interpreter
// assumes one clock domain shared by the bus, the media engine and this block
package scsiwv_pkg;
  localparam int           ADDR_W       = 8;
  // register byte offsets
  localparam logic [7:0]   OFS_CDB0     = 8'h00;
  localparam logic [7:0]   OFS_CDB1     = 8'h04;
  localparam logic [7:0]   OFS_CDB2     = 8'h08;
  localparam logic [7:0]   OFS_CTRL     = 8'h0C;
  localparam logic [7:0]   OFS_BLKLEN   = 8'h10;
  localparam logic [7:0]   OFS_STATUS   = 8'h14;
  localparam logic [7:0]   OFS_LASTLBA  = 8'h18;
  // control fields
  localparam int           CTRL_GO      = 0;
  localparam int           CTRL_WCE     = 1;
  localparam logic [15:0]  BLKLEN_RST   = 16'h0200;
  // status fields
  localparam int           STS_BUSY     = 0;
  localparam int           STS_FLUSH    = 1;
  localparam int           STS_DFR      = 2;
  localparam int           STS_DFRSEEN  = 3;
  localparam int           STS_CODE_LO  = 8;
  localparam int           STS_KEY_LO   = 16;
  localparam int           STS_ASC_LO   = 24;
  // descriptor fields
  localparam logic [7:0]   OPC_VERIFY   = 8'h2F;
  localparam logic [7:0]   OPC_WRITE6   = 8'h0A;
  localparam logic [7:0]   OPC_WRITE10  = 8'h2A;
  localparam logic [7:0]   OPC_WRVFY    = 8'h2E;
  localparam int           B1_RELATIVE_ADDRESS_FLAG    = 0;
  localparam int           B1_BYTCMP    = 1;
  localparam int           B1_FORCE     = 3;
  localparam int           W6_LBA_HI_W  = 5;
  localparam logic [16:0]  W6_ZERO_CNT  = 17'h00100;
  localparam logic [32:0]  BYTCMP_LIMIT = 33'h000008000;
  // status and sense values
  localparam logic [7:0]   ST_GOOD      = 8'h00;
  localparam logic [7:0]   ST_CHECK     = 8'h02;
  localparam logic [3:0]   KEY_NONE     = 4'h0;
  localparam logic [3:0]   KEY_MEDIUM   = 4'h3;
  localparam logic [3:0]   KEY_ILLEGAL  = 4'h5;
  localparam logic [3:0]   KEY_MISCMP   = 4'hE;
  localparam logic [7:0]   ASC_NONE     = 8'h00;
  localparam logic [7:0]   ASC_WR_ERR   = 8'h0C;
  localparam logic [7:0]   ASC_RD_ERR   = 8'h11;
  localparam logic [7:0]   ASC_CMP_ERR  = 8'h1D;
  localparam logic [7:0]   ASC_BAD_OPC  = 8'h20;
  localparam logic [7:0]   ASC_BAD_FLD  = 8'h24;
  // media operations
  localparam logic [1:0]   MOP_VERIFY   = 2'h0;
  localparam logic [1:0]   MOP_WRITE    = 2'h1;
  localparam logic [1:0]   MOP_WRVFY    = 2'h2;

  typedef enum logic [1:0] {
    SCSIWV_IDLE   = 2'b00,
    SCSIWV_DECODE = 2'b01,
    SCSIWV_WAIT   = 2'b10
  } scsiwv_state_t;
endpackage

// ### hw/scsiwv_core.sv
// write, verify and write-and-verify command interpreter with an APB register file
// assumes the media engine runs on pclk and answers no earlier than the cycle after med_req
`timescale 1ns/1ps
`default_nettype none

module scsiwv_core (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [scsiwv_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               med_req,
  output logic      [1:0]                    med_op,
  output logic      [31:0]                   med_lba,
  output logic      [16:0]                   med_count,
  output logic      [32:0]                   med_xfer_bytes,
  output logic                               med_compare,
  output logic                               med_need_data,
  output logic                               med_force,
  input  wire logic                          med_staged,
  input  wire logic                          med_done,
  input  wire logic                          med_miscmp,
  input  wire logic                          med_rd_err,
  input  wire logic                          med_wr_err,
  output logic                               cmd_done
);
  typedef struct packed {
    scsiwv_pkg::scsiwv_state_t state;
    logic [31:0] cdb0;
    logic [31:0] cdb1;
    logic [15:0] cdb2;
    logic        go_pend;
    logic        write_cache_enable;
    logic [15:0] blk_len;
    logic [7:0]  stat;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic        flush_pend;
    logic        dfr_pend;
    logic [3:0]  dfr_key;
    logic [7:0]  dfr_asc;
    logic        dfr_seen;
    logic [31:0] last_lba;
    logic        early_ok;
    logic        med_req;
    logic [1:0]  med_op;
    logic [31:0] med_lba;
    logic [16:0] med_count;
    logic [32:0] med_bytes;
    logic        med_cmp;
    logic        med_data;
    logic        med_force;
    logic        cmd_done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scsiwv_st_t;
  scsiwv_st_t st_r;
  scsiwv_st_t st_nxt;
  function automatic logic [7:0] cdb_byte(input scsiwv_st_t s, input int idx);
    logic [79:0] all;
    all = {s.cdb2, s.cdb1, s.cdb0};
    return all[idx*8 +: 8];
  endfunction
  logic [7:0]  d_op;
  logic [7:0]  d_b1;
  logic        d_vfy;
  logic        d_w6;
  logic        d_w10;
  logic        d_wv;
  logic [31:0] d_lba;
  logic [16:0] d_cnt;
  logic        d_cmp;
  logic        d_rel;
  logic [32:0] d_bytes;
  logic [31:0] d_target;
  logic        bus_rd;
  logic        bus_wr;
  logic        hit;
  logic [31:0] rd_word;
  logic        busy;
  logic        fail;
  logic [3:0]  fail_key;
  logic [7:0]  fail_asc;
  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_done = 1'b0;
    st_nxt.med_req = 1'b0;
    busy = (st_r.state != scsiwv_pkg::SCSIWV_IDLE) || st_r.go_pend;
    d_op  = cdb_byte(st_r, 0);
    d_b1  = cdb_byte(st_r, 1);
    d_vfy = (d_op == scsiwv_pkg::OPC_VERIFY);
    d_w6  = (d_op == scsiwv_pkg::OPC_WRITE6);
    d_w10 = (d_op == scsiwv_pkg::OPC_WRITE10);
    d_wv  = (d_op == scsiwv_pkg::OPC_WRVFY);
    if (d_w6) begin
      d_lba = {11'h000, d_b1[scsiwv_pkg::W6_LBA_HI_W-1:0], cdb_byte(st_r, 2),
               cdb_byte(st_r, 3)};
      d_cnt = (cdb_byte(st_r, 4) == 8'h00) ? scsiwv_pkg::W6_ZERO_CNT
              : {9'h000, cdb_byte(st_r, 4)};
    end else begin
      d_lba = {cdb_byte(st_r, 2), cdb_byte(st_r, 3),
               cdb_byte(st_r, 4), cdb_byte(st_r, 5)};
      d_cnt = {1'b0, cdb_byte(st_r, 7), cdb_byte(st_r, 8)};
    end
    d_cmp    = (d_vfy || d_wv) && d_b1[scsiwv_pkg::B1_BYTCMP];
    d_rel    = d_w10 && d_b1[scsiwv_pkg::B1_RELATIVE_ADDRESS_FLAG];
    d_bytes  = 33'(d_cnt * st_r.blk_len);
    // signed offset wraps naturally in a 32-bit sum
    d_target = d_rel ? 32'(st_r.last_lba + d_lba) : d_lba;
    // media result: unreadable data outranks a mismatch
    fail     = med_rd_err || med_wr_err || med_miscmp;
    fail_key = scsiwv_pkg::KEY_MISCMP;
    fail_asc = scsiwv_pkg::ASC_CMP_ERR;
    if (med_rd_err) begin
      fail_key = scsiwv_pkg::KEY_MEDIUM;
      fail_asc = scsiwv_pkg::ASC_RD_ERR;
    end else if (med_wr_err) begin
      fail_key = scsiwv_pkg::KEY_MEDIUM;
      fail_asc = scsiwv_pkg::ASC_WR_ERR;
    end
    if (st_r.flush_pend && med_done) begin
      st_nxt.flush_pend = 1'b0;
      if (fail) begin
        st_nxt.dfr_pend = 1'b1;
        st_nxt.dfr_key  = fail_key;
        st_nxt.dfr_asc  = fail_asc;
      end
    end
    unique case (st_r.state)
      scsiwv_pkg::SCSIWV_IDLE: begin
        // a new command waits until the cache flush has finished
        if (st_r.go_pend && !st_r.flush_pend) begin
          st_nxt.go_pend = 1'b0;
          st_nxt.state   = scsiwv_pkg::SCSIWV_DECODE;
        end
      end
      scsiwv_pkg::SCSIWV_DECODE: begin
        st_nxt.state    = scsiwv_pkg::SCSIWV_IDLE;
        st_nxt.cmd_done = 1'b1;
        st_nxt.stat     = scsiwv_pkg::ST_GOOD;
        st_nxt.key      = scsiwv_pkg::KEY_NONE;
        st_nxt.asc      = scsiwv_pkg::ASC_NONE;
        st_nxt.dfr_seen = 1'b0;
        if (st_r.dfr_pend) begin
          // the held error ends this command in place of running it
          st_nxt.dfr_pend = 1'b0;
          st_nxt.dfr_seen = 1'b1;
          st_nxt.stat     = scsiwv_pkg::ST_CHECK;
          st_nxt.key      = st_r.dfr_key;
          st_nxt.asc      = st_r.dfr_asc;
        end else if (!(d_vfy || d_w6 || d_w10 || d_wv)) begin
          st_nxt.stat = scsiwv_pkg::ST_CHECK;
          st_nxt.key  = scsiwv_pkg::KEY_ILLEGAL;
          st_nxt.asc  = scsiwv_pkg::ASC_BAD_OPC;
        end else if (d_cmp && (d_bytes > scsiwv_pkg::BYTCMP_LIMIT)) begin
          st_nxt.stat = scsiwv_pkg::ST_CHECK;
          st_nxt.key  = scsiwv_pkg::KEY_ILLEGAL;
          st_nxt.asc  = scsiwv_pkg::ASC_BAD_FLD;
        end else if (d_cnt == 17'h00000) begin
          // seek-like: nothing moves, the address still counts as accessed
          st_nxt.last_lba = d_target;
        end else begin
          st_nxt.state     = scsiwv_pkg::SCSIWV_WAIT;
          st_nxt.cmd_done  = 1'b0;
          st_nxt.med_req   = 1'b1;
          st_nxt.med_lba   = d_target;
          st_nxt.med_count = d_cnt;
          st_nxt.med_bytes = d_bytes;
          st_nxt.med_cmp   = d_cmp;
          st_nxt.med_data  = !d_vfy || d_cmp;
          st_nxt.med_force = d_w10 && d_b1[scsiwv_pkg::B1_FORCE];
          st_nxt.med_op    = d_vfy ? scsiwv_pkg::MOP_VERIFY
                             : (d_wv ? scsiwv_pkg::MOP_WRVFY
                                     : scsiwv_pkg::MOP_WRITE);
          st_nxt.early_ok  = !d_vfy && !d_wv && st_r.write_cache_enable
                             && !(d_w10 && d_b1[scsiwv_pkg::B1_FORCE]);
          st_nxt.last_lba  = 32'(d_target + {15'h0000, d_cnt} - 32'h00000001);
        end
      end
      scsiwv_pkg::SCSIWV_WAIT: begin
        if (med_done) begin
          st_nxt.state    = scsiwv_pkg::SCSIWV_IDLE;
          st_nxt.cmd_done = 1'b1;
          if (fail) begin
            st_nxt.stat = scsiwv_pkg::ST_CHECK;
            st_nxt.key  = fail_key;
            st_nxt.asc  = fail_asc;
          end
        end else if (med_staged && st_r.early_ok) begin
          st_nxt.state      = scsiwv_pkg::SCSIWV_IDLE;
          st_nxt.cmd_done   = 1'b1;
          st_nxt.flush_pend = 1'b1;
        end
      end
      default: begin
        st_nxt.state = scsiwv_pkg::SCSIWV_IDLE;
      end
    endcase
    // APB: one wait state, data and reply settle on the same edge that pready rises
    bus_rd = psel && penable && !st_r.pready;
    bus_wr = psel && penable && st_r.pready && pwrite;
    hit    = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      scsiwv_pkg::OFS_CDB0:    rd_word = st_r.cdb0;
      scsiwv_pkg::OFS_CDB1:    rd_word = st_r.cdb1;
      scsiwv_pkg::OFS_CDB2:    rd_word = {16'h0000, st_r.cdb2};
      scsiwv_pkg::OFS_CTRL:    rd_word = {30'h00000000, st_r.write_cache_enable, st_r.go_pend};
      scsiwv_pkg::OFS_BLKLEN:  rd_word = {16'h0000, st_r.blk_len};
      scsiwv_pkg::OFS_STATUS: begin
        rd_word[scsiwv_pkg::STS_BUSY]    = busy;
        rd_word[scsiwv_pkg::STS_FLUSH]   = st_r.flush_pend;
        rd_word[scsiwv_pkg::STS_DFR]     = st_r.dfr_pend;
        rd_word[scsiwv_pkg::STS_DFRSEEN] = st_r.dfr_seen;
        rd_word[scsiwv_pkg::STS_CODE_LO +: 8] = st_r.stat;
        rd_word[scsiwv_pkg::STS_KEY_LO +: 4]  = st_r.key;
        rd_word[scsiwv_pkg::STS_ASC_LO +: 8]  = st_r.asc;
      end
      scsiwv_pkg::OFS_LASTLBA: rd_word = st_r.last_lba;
      default:                 hit = 1'b0;
    endcase
    st_nxt.pready = bus_rd;
    if (bus_rd) begin
      st_nxt.prdata  = pwrite ? 32'h00000000 : rd_word;
      st_nxt.pslverr = !hit;
    end
    if (bus_wr) begin
      unique case (paddr)
        scsiwv_pkg::OFS_CDB0:   st_nxt.cdb0 = pwdata;
        scsiwv_pkg::OFS_CDB1:   st_nxt.cdb1 = pwdata;
        scsiwv_pkg::OFS_CDB2:   st_nxt.cdb2 = pwdata[15:0];
        scsiwv_pkg::OFS_BLKLEN: st_nxt.blk_len = pwdata[15:0];
        scsiwv_pkg::OFS_CTRL: begin
          st_nxt.write_cache_enable = pwdata[scsiwv_pkg::CTRL_WCE];
          // a start while busy is dropped; software polls busy first
          if (pwdata[scsiwv_pkg::CTRL_GO] && !busy) begin
            st_nxt.go_pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.state   <= scsiwv_pkg::SCSIWV_IDLE;
      st_r.blk_len <= scsiwv_pkg::BLKLEN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign prdata         = st_r.prdata;
  assign pready         = st_r.pready;
  assign pslverr        = st_r.pslverr;
  assign med_req        = st_r.med_req;
  assign med_op         = st_r.med_op;
  assign med_lba        = st_r.med_lba;
  assign med_count      = st_r.med_count;
  assign med_xfer_bytes = st_r.med_bytes;
  assign med_compare    = st_r.med_cmp;
  assign med_need_data  = st_r.med_data;
  assign med_force      = st_r.med_force;
  assign cmd_done       = st_r.cmd_done;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_dec_zero;
    st_r.state == scsiwv_pkg::SCSIWV_DECODE && !st_r.dfr_pend && !d_w6
      && (d_vfy || d_w10 || d_wv) && d_cnt == 17'h00000;
  endsequence
  sequence s_good_done;
    cmd_done && st_r.stat == scsiwv_pkg::ST_GOOD && !med_req;
  endsequence
  sequence s_wait_end(logic [3:0] k);
    st_r.state == scsiwv_pkg::SCSIWV_WAIT && med_done && !st_r.flush_pend
      && fail_key == k;
  endsequence
  property p_zero_count_good;
    s_dec_zero |=> s_good_done;
  endproperty
  a_zero_count_good: assert property (p_zero_count_good) else $error("zero count");
  property p_cmp_limit;
    st_r.state == scsiwv_pkg::SCSIWV_DECODE && !st_r.dfr_pend && d_cmp
      && d_bytes > scsiwv_pkg::BYTCMP_LIMIT
      |=> cmd_done && st_r.key == scsiwv_pkg::KEY_ILLEGAL
          && st_r.asc == scsiwv_pkg::ASC_BAD_FLD && !med_req;
  endproperty
  a_cmp_limit: assert property (p_cmp_limit) else $error("oversize compare run");
  property p_miscmp;
    s_wait_end(scsiwv_pkg::KEY_MISCMP) ##0 med_miscmp
      |=> cmd_done && st_r.stat == scsiwv_pkg::ST_CHECK
          && st_r.asc == scsiwv_pkg::ASC_CMP_ERR;
  endproperty
  a_miscmp: assert property (p_miscmp) else $error("miscompare not reported");
  property p_rd_err;
    st_r.state == scsiwv_pkg::SCSIWV_WAIT && med_done && med_rd_err
      |=> st_r.key == scsiwv_pkg::KEY_MEDIUM && st_r.stat == scsiwv_pkg::ST_CHECK;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("read failure not medium error");
  property p_force_holds;
    st_r.state == scsiwv_pkg::SCSIWV_WAIT && st_r.med_force && med_staged && !med_done
      |=> st_r.state == scsiwv_pkg::SCSIWV_WAIT && !cmd_done;
  endproperty
  a_force_holds: assert property (p_force_holds) else $error("forced write ended early");
  property p_early_good;
    st_r.state == scsiwv_pkg::SCSIWV_WAIT && st_r.early_ok && med_staged && !med_done
      |=> cmd_done && st_r.flush_pend ##1 st_r.state == scsiwv_pkg::SCSIWV_IDLE;
  endproperty
  a_early_good: assert property (p_early_good) else $error("cached write not early");
  property p_deferred;
    st_r.flush_pend && med_done && fail
      |=> st_r.dfr_pend && st_r.dfr_key == $past(fail_key);
  endproperty
  a_deferred: assert property (p_deferred) else $error("late error not held");
  property p_w6_zero;
    st_r.state == scsiwv_pkg::SCSIWV_DECODE && !st_r.dfr_pend && d_w6
      && cdb_byte(st_r, 4) == 8'h00
      |=> med_req && med_count == scsiwv_pkg::W6_ZERO_CNT;
  endproperty
  a_w6_zero: assert property (p_w6_zero) else $error("short write zero count not 256");
  property p_rel_addr;
    st_r.state == scsiwv_pkg::SCSIWV_DECODE && !st_r.dfr_pend && d_rel && d_cnt != 17'h00000
      && !d_cmp |=> med_lba == 32'($past(st_r.last_lba) + $past(d_lba));
  endproperty
  a_rel_addr: assert property (p_rel_addr) else $error("relative address wrong");
  property p_need_data;
    med_req |-> med_need_data == (med_op != scsiwv_pkg::MOP_VERIFY || med_compare) ##1 !med_req;
  endproperty
  a_need_data: assert property (p_need_data) else $error("data request flag wrong");
endmodule // scsiwv_core

`default_nettype wire

// ### tb/scsiwv_media_model.sv
// media engine stand-in: answers every med_req after a random delay
// assumes the bench picks the error flags that go out with med_done
`timescale 1ns/1ps
`default_nettype none
module scsiwv_media_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       med_req,
  input  wire logic [1:0] med_op,
  input  wire logic [2:0] err_sel,
  output logic            med_staged,
  output logic            med_done,
  output logic            med_miscmp,
  output logic            med_rd_err,
  output logic            med_wr_err
);
  // flags mean nothing outside med_done, so they are noise there
  task automatic tick(input logic s, input logic d);
    @(posedge pclk);
    med_staged <= s;
    med_done   <= d;
    {med_wr_err, med_rd_err, med_miscmp} <= d ? err_sel : 3'($urandom);
  endtask

  initial begin
    med_staged = 1'b0;
    med_done   = 1'b0;
    {med_wr_err, med_rd_err, med_miscmp} = 3'b000;
    forever begin
      tick(1'b0, 1'b0);
      if (med_req === 1'b1 && presetn) begin
        if (med_op == scsiwv_pkg::MOP_WRITE) tick(1'b1, 1'b0);
        repeat ($urandom_range(6, 1)) tick(1'b0, 1'b0);
        tick(1'b0, 1'b1);
      end
    end
  end
endmodule // scsiwv_media_model
`default_nettype wire

// ### tb/scsiwv_core_test.sv
// self-checking bench for the write/verify interpreter, driven over APB
// assumes the media model answers every med_req that it sees
`timescale 1ns/1ps
`default_nettype none
module scsiwv_core_test;
  typedef struct packed {
    logic [1:0]  op;
    logic [31:0] lba;
    logic [16:0] cnt;
    logic [32:0] bytes;
    logic [2:0]  flg;
  } scsiwv_exp_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  err_sel = 3'b000;
  logic [31:0] prdata, med_lba;
  logic [16:0] med_count;
  logic [32:0] med_xfer_bytes;
  logic [1:0]  med_op;
  logic        pready, pslverr, med_req, med_compare, med_need_data, med_force;
  logic        med_staged, med_done, med_miscmp, med_rd_err, med_wr_err, cmd_done;
  int          num_errors = 0;
  int          cmp_count = 0;
  scsiwv_exp_t exp_q[$];
  localparam logic [31:0] GOOD = 32'h0;

  always #50 pclk = ~pclk;

  scsiwv_core scsiwv_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .med_req, .med_op, .med_lba, .med_count, .med_xfer_bytes,
    .med_compare, .med_need_data, .med_force, .med_staged, .med_done, .med_miscmp,
    .med_rd_err, .med_wr_err, .cmd_done);
  scsiwv_media_model scsiwv_media_model_i (.pclk, .presetn, .med_req, .med_op, .err_sel,
    .med_staged, .med_done, .med_miscmp, .med_rd_err, .med_wr_err);

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // one idle cycle before each setup keeps psel from being driven twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    limit(n, 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [95:0] c10(input logic [7:0] o, input logic [7:0] f,
                                      input logic [31:0] a, input logic [15:0] n);
    return {24'h0, n[7:0], n[15:8], 8'h00, a[7:0], a[15:8], a[23:16], a[31:24],
            f & 8'hEF, o};
  endfunction

  function automatic logic [95:0] c6(input logic [20:0] a, input logic [7:0] n);
    return {56'h0, n, a[7:0], a[15:8], 3'b000, a[20:16], 8'h0A};
  endfunction

  function automatic scsiwv_exp_t ex(input logic [1:0] op, input logic [31:0] a,
                                     input logic [16:0] n, input logic [2:0] f);
    return '{op, a, n, 33'(n) * 33'(scsiwv_pkg::BLKLEN_RST), f};
  endfunction

  function automatic logic [31:0] st(input logic [3:0] k, input logic [7:0] a,
                                     input logic d);
    return {a, 4'h0, k, scsiwv_pkg::ST_CHECK, 4'h0, d, 3'b000};
  endfunction

  // whoever starts a command notes the media start it expects
  task automatic run(input logic [95:0] c, input logic [2:0] err, input logic write_cache_enable,
                     input logic med, input scsiwv_exp_t x, input logic [31:0] s);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, scsiwv_pkg::OFS_STATUS, 32'h0, r, e);
      n++;
    end while (r[1:0] !== 2'b00 && n < 200);
    limit(n, 200);
    apb(1'b1, scsiwv_pkg::OFS_CDB0, c[31:0], r, e);
    apb(1'b1, scsiwv_pkg::OFS_CDB1, c[63:32], r, e);
    apb(1'b1, scsiwv_pkg::OFS_CDB2, c[95:64], r, e);
    err_sel <= err;
    if (med) exp_q.push_back(x);
    apb(1'b1, scsiwv_pkg::OFS_CTRL, {30'h0, write_cache_enable, 1'b1}, r, e);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cmd_done !== 1'b1 && n < 2000);
    limit(n, 2000);
    apb(1'b0, scsiwv_pkg::OFS_STATUS, 32'h0, r, e);
    check(r & 32'hFF0F_FF08, s);
    check(exp_q.size(), 0);
  endtask

  // watcher: each media start takes the oldest note
  always @(posedge pclk) begin
    if (med_req === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check({med_op, med_lba, med_count, med_xfer_bytes, med_compare, med_need_data,
                  med_force}, exp_q.pop_front());
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] l;
    logic        e;
    void'($urandom(34));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, scsiwv_pkg::OFS_BLKLEN, 32'h0, r, e);
    check(r[15:0], scsiwv_pkg::BLKLEN_RST);
    apb(1'b1, scsiwv_pkg::OFS_STATUS, 32'hFFFF_FFFF, r, e);
    apb(1'b0, scsiwv_pkg::OFS_STATUS, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b0, scsiwv_pkg::OFS_CTRL, 32'h0, r, e);
    check({e, r}, 33'h0);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    check({e, r}, {1'b1, 32'h0});
    l = $urandom;
    run(c10(8'h2F, 8'h00, l, 16'h4), 3'b000, 1'b0, 1'b1, ex(2'h0, l, 17'h4, 3'b000), GOOD);
    run(c10(8'h2A, 8'h01, 32'hFFFF_FFFE, 16'h3), 3'b000, 1'b0, 1'b1,
        ex(2'h1, l + 32'h1, 17'h3, 3'b010), GOOD);
    apb(1'b0, scsiwv_pkg::OFS_LASTLBA, 32'h0, r, e);
    check(r, l + 32'h3);
    run(c10(8'h2F, 8'h02, 32'h40, 16'd64), 3'b001, 1'b0, 1'b1,
        ex(2'h0, 32'h40, 17'd64, 3'b110), st(4'hE, 8'h1D, 1'b0));
    run(c10(8'h2F, 8'h02, 32'h40, 16'd65), 3'b000, 1'b0, 1'b0, '0, st(4'h5, 8'h24, 1'b0));
    run(c10(8'h2F, 8'h00, 32'h77, 16'h0), 3'b000, 1'b0, 1'b0, '0, GOOD);
    run(c6(21'h1ABCDE, 8'h00), 3'b000, 1'b0, 1'b1,
        ex(2'h1, 32'h001A_BCDE, 17'd256, 3'b010), GOOD);
    run(c10(8'h2A, 8'h08, 32'h100, 16'h2), 3'b100, 1'b1, 1'b1,
        ex(2'h1, 32'h100, 17'h2, 3'b011), st(4'h3, 8'h0C, 1'b0));
    run(c10(8'h2A, 8'h00, 32'h200, 16'h0), 3'b000, 1'b0, 1'b0, '0, GOOD);
    run(c10(8'h2A, 8'h00, 32'h300, 16'h1), 3'b100, 1'b1, 1'b1,
        ex(2'h1, 32'h300, 17'h1, 3'b010), GOOD);
    run(c10(8'h2F, 8'h00, 32'h5, 16'h0), 3'b000, 1'b0, 1'b0, '0, st(4'h3, 8'h0C, 1'b1));
    run(c10(8'h2E, 8'h02, 32'h9, 16'd65), 3'b000, 1'b0, 1'b0, '0, st(4'h5, 8'h24, 1'b0));
    run(c10(8'h2E, 8'h00, 32'h9, 16'h2), 3'b010, 1'b0, 1'b1,
        ex(2'h2, 32'h9, 17'h2, 3'b010), st(4'h3, 8'h11, 1'b0));
    run(c10(8'h2E, 8'h00, 32'h9, 16'h0), 3'b000, 1'b0, 1'b0, '0, GOOD);
    run(c10(8'h2E, 8'h02, 32'hA, 16'd64), 3'b001, 1'b0, 1'b1,
        ex(2'h2, 32'hA, 17'd64, 3'b110), st(4'hE, 8'h1D, 1'b0));
    run(c10(8'h00, 8'h00, 32'h0, 16'h1), 3'b000, 1'b0, 1'b0, '0, st(4'h5, 8'h20, 1'b0));
    tally_and_finish();
  end
endmodule // scsiwv_core_test
`default_nettype wire
